// [pkg/pic_host_defs.vh]
`ifndef PIC_HOST_DEFS_VH
`define PIC_HOST_DEFS_VH
// Software register indexes of the controller
`define REG_CTRL 4'h0
`define REG_WDATA 4'h1
`define REG_STATUS 4'h2
`define REG_RDATA 4'h3
`define REG_VEC0 4'h4
`define REG_VEC1 4'h5
`define REG_VEC2 4'h6
// Control register fields
`define CTRL_GO_WR 0
`define CTRL_GO_RD 1
`define CTRL_ADDR 2
`define CTRL_AUTO_ACK 3
`define CTRL_MODE16 4
`define CTRL_RESET 8'h00
// Device call opcode expected on the first acknowledge in 8-bit mode
`define CALL_OPCODE 8'hCD
// Strobe low time and recovery, in ns
`define STROBE_NS 300
`define RECOVER_NS 200
`define CLK_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [rtl/pic_host_ctrl.v]
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
`include "pic_host_defs.vh"

// Contract
// - Host writes a command word with write low and select low.
// - Host reads status with read low and select low; device drives data.
// - Edge mode: rising edge, held high until acknowledged; the controller acknowledges on the irq_sync level, not on an edge.
// - Processor issues acknowledge pulses; device returns vector bytes.
module pic_host_ctrl
#(
  parameter STROBE_CYC = `STROBE_CYC,
  parameter RECOVER_CYC = `RECOVER_CYC
)
(
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Software port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Device bus pins
  input wire [7:0] dev_data_i,
  output wire [7:0] dev_data_o,
  output wire dev_data_oe_o,
  output wire select_n_o,
  output wire rd_n_o,
  output wire wr_n_o,
  output wire cmd_select_addr_o,
  output wire irq_ack_strobe_n_o,
  // Device interrupt line
  input wire irq_i
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_WR = 3'h1;
  localparam S_RD = 3'h2;
  localparam S_ACK = 3'h3;
  localparam S_GAP = 3'h4;

  reg [2:0] state_ff, nxt_state;
  reg [7:0] cnt_ff, nxt_cnt;
  reg [7:0] ctrl_ff, nxt_ctrl;
  reg [7:0] wdata_ff, nxt_wdata;
  reg [7:0] rdbyte_ff, nxt_rdbyte;
  reg [1:0] ack_idx_ff, nxt_ack_idx;
  reg [7:0] vec0_ff, vec1_ff, vec2_ff;
  reg [7:0] nxt_vec0, nxt_vec1, nxt_vec2;
  reg ack_done_ff, nxt_ack_done;
  reg op_err_ff, nxt_op_err;
  reg [1:0] irq_sync_ff;
  reg [7:0] din_s1_ff, din_s2_ff;
  reg [7:0] nxt_rdata;

  wire irq_sync = irq_sync_ff[1];
  wire mode16 = ctrl_ff[`CTRL_MODE16];
  wire [1:0] ack_last = mode16 ? 2'h1 : 2'h2;
  wire busy = (state_ff != S_IDLE);
  wire sw_wr_ctrl = wr_i && (addr_i == `REG_CTRL);

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Select held low for the whole access, strobes only inside it
  assign select_n_o = !((state_ff == S_WR) || (state_ff == S_RD));
  assign wr_n_o = !(state_ff == S_WR);
  assign rd_n_o = !(state_ff == S_RD);
  // Acknowledge leaves select high on purpose
  assign irq_ack_strobe_n_o = !(state_ff == S_ACK);
  assign cmd_select_addr_o = ctrl_ff[`CTRL_ADDR];
  // Host drives data only while writing, so the device owns it on answers
  assign dev_data_o = wdata_ff;
  assign dev_data_oe_o = (state_ff == S_WR);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ctrl = ctrl_ff;
    nxt_wdata = wdata_ff;
    nxt_rdbyte = rdbyte_ff;
    nxt_ack_idx = ack_idx_ff;
    nxt_vec0 = vec0_ff;
    nxt_vec1 = vec1_ff;
    nxt_vec2 = vec2_ff;
    nxt_ack_done = ack_done_ff;
    nxt_op_err = op_err_ff;
    // Go bits are pulses; software writes to control and write data while busy are dropped
    nxt_ctrl[`CTRL_GO_WR] = 1'b0;
    nxt_ctrl[`CTRL_GO_RD] = 1'b0;
    if (sw_wr_ctrl && !busy)
    begin
      nxt_ctrl = wdata_i;
    end
    if (wr_i && (addr_i == `REG_WDATA) && !busy)
    begin
      nxt_wdata = wdata_i;
    end
    if (wr_i && (addr_i == `REG_STATUS))
    begin
      nxt_ack_done = 1'b0;
      nxt_op_err = 1'b0;
    end
    case (state_ff)
      S_IDLE:
      begin
        nxt_cnt = 8'h00;
        if (ctrl_ff[`CTRL_GO_WR])
        begin
          nxt_state = S_WR;
        end
        else if (ctrl_ff[`CTRL_GO_RD])
        begin
          nxt_state = S_RD;
        end
        else if (ctrl_ff[`CTRL_AUTO_ACK] && irq_sync)
        begin
          nxt_state = S_ACK;
          nxt_ack_idx = 2'h0;
        end
      end
      S_WR, S_RD:
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == STROBE_CYC[7:0] - 8'h01)
        begin
          // Sample the status byte at the end of the read strobe
          if (state_ff == S_RD)
          begin
            nxt_rdbyte = din_s2_ff;
          end
          nxt_state = S_GAP;
          nxt_cnt = 8'h00;
        end
      end
      S_ACK:
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == STROBE_CYC[7:0] - 8'h01)
        begin
          // 8-bit mode: opcode, low, high; 16-bit mode: silent, vector
          case (ack_idx_ff)
            2'h0: nxt_vec0 = din_s2_ff;
            2'h1: nxt_vec1 = din_s2_ff;
            default: nxt_vec2 = din_s2_ff;
          endcase
          if (!mode16 && (ack_idx_ff == 2'h0) && (din_s2_ff != `CALL_OPCODE))
          begin
            nxt_op_err = 1'b1;
          end
          if (ack_idx_ff == ack_last)
          begin
            nxt_ack_done = 1'b1;
            nxt_ack_idx = 2'h0;
            nxt_state = S_GAP;
          end
          else
          begin
            nxt_ack_idx = ack_idx_ff + 2'h1;
            nxt_state = S_GAP;
          end
          nxt_cnt = 8'h00;
        end
      end
      S_GAP:
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff >= RECOVER_CYC[7:0] - 8'h01)
        begin
          nxt_cnt = 8'h00;
          nxt_state = (ack_idx_ff != 2'h0) ? S_ACK : S_IDLE;
        end
      end
      default:
      begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    case (addr_i)
      `REG_CTRL: nxt_rdata = ctrl_ff;
      `REG_WDATA: nxt_rdata = wdata_ff;
      `REG_STATUS: nxt_rdata = {4'h0, op_err_ff, ack_done_ff, irq_sync, busy};
      `REG_RDATA: nxt_rdata = rdbyte_ff;
      `REG_VEC0: nxt_rdata = vec0_ff;
      `REG_VEC1: nxt_rdata = vec1_ff;
      `REG_VEC2: nxt_rdata = vec2_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      ctrl_ff <= `CTRL_RESET;
      wdata_ff <= 8'h00;
      rdbyte_ff <= 8'h00;
      ack_idx_ff <= 2'h0;
      vec0_ff <= 8'h00;
      vec1_ff <= 8'h00;
      vec2_ff <= 8'h00;
      ack_done_ff <= 1'b0;
      op_err_ff <= 1'b0;
      irq_sync_ff <= 2'h0;
      din_s1_ff <= 8'h00;
      din_s2_ff <= 8'h00;
      rdata_o <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ctrl_ff <= nxt_ctrl;
      wdata_ff <= nxt_wdata;
      rdbyte_ff <= nxt_rdbyte;
      ack_idx_ff <= nxt_ack_idx;
      vec0_ff <= nxt_vec0;
      vec1_ff <= nxt_vec1;
      vec2_ff <= nxt_vec2;
      ack_done_ff <= nxt_ack_done;
      op_err_ff <= nxt_op_err;
      // Pins come from an unclocked device, so two flops first
      irq_sync_ff <= {irq_sync_ff[0], irq_i};
      din_s1_ff <= dev_data_i;
      din_s2_ff <= din_s1_ff;
      rdata_o <= rd_i ? nxt_rdata : 8'h00;
    end
  end

endmodule // pic_host_ctrl

// [test/pic_host_sva.sv]
`timescale 1ns/1ns
module pic_host_sva (
  input wire clk_i, input wire rstn_i, input wire [3:0] addr_i, input wire [7:0] wdata_i,
  input wire wr_i, input wire rd_i, input wire [7:0] rdata_o, input wire [7:0] dev_data_i,
  input wire [7:0] dev_data_o, input wire dev_data_oe_o, input wire select_n_o,
  input wire rd_n_o, input wire wr_n_o, input wire cmd_select_addr_o,
  input wire irq_ack_strobe_n_o, input wire irq_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_WR_SEL: assert property (!wr_n_o |-> !select_n_o)
    else $error("write strobe without select");
  AST_RD_SEL: assert property (!rd_n_o |-> !select_n_o)
    else $error("read strobe without select");
  AST_ACK_NOSEL: assert property (!irq_ack_strobe_n_o |-> select_n_o)
    else $error("acknowledge with select low");
  AST_OE_WR: assert property (dev_data_oe_o == !wr_n_o)
    else $error("bus drive outside write strobe");
  AST_WR_LEN: assert property ($fell(wr_n_o) |-> !wr_n_o [*3] ##1 wr_n_o [*2])
    else $error("write strobe length wrong");
  AST_ACK_LEN: assert property ($fell(irq_ack_strobe_n_o) |-> !irq_ack_strobe_n_o [*3] ##1 irq_ack_strobe_n_o)
    else $error("acknowledge pulse length wrong");
  AST_RD_DATA: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  AST_NO_BOTH: assert property ($onehot0({!rd_n_o, !wr_n_o, !irq_ack_strobe_n_o}))
    else $error("two device strobes at once");
  AST_WDATA_STABLE: assert property (!wr_n_o && !$fell(wr_n_o) |-> $stable(dev_data_o))
    else $error("write byte moved in a strobe");
  AST_ADDR_STABLE: assert property (!select_n_o && !$fell(select_n_o) |-> $stable(cmd_select_addr_o))
    else $error("command address moved in a strobe");
endmodule // pic_host_sva
bind pic_host_ctrl pic_host_sva chk (.*);

// [test/dev_model.sv]
`timescale 1ns/1ns
module dev_model (
  input wire sel_n, input wire rd_n, input wire wr_n, input wire a0, input wire ack_n,
  input wire oe, input wire [7:0] hd, input wire m16, input wire req,
  output reg [7:0] d, output wire irq
);
  reg [7:0] cmd [0:1];
  reg [7:0] last = 8'h00;
  reg [1:0] n = 2'h0;
  assign irq = req;
  // Level capture: select and strobe rise in one step, an edge capture would race
  always @* if (!wr_n && !sel_n && oe) cmd[a0] = hd;
  always @(negedge ack_n) n <= (n >= (m16 ? 2'h2 : 2'h3)) ? 2'h1 : n + 2'h1;
  always @(posedge rd_n or posedge ack_n) last <= d;
  always @*
  begin
    if (!rd_n && !sel_n) d = cmd[a0] ^ 8'h5A;
    else if (!ack_n && !m16) d = n == 2'h1 ? 8'hCD : n == 2'h2 ? 8'h34 : 8'h12;
    else if (!ack_n && n == 2'h2) d = 8'h40;
    else d = ~last;
  end
endmodule // dev_model

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "pic_host_defs.vh"
module tb_top;
  reg clk_i, rstn_i, wr_i, rd_i, req, m16;
  reg [3:0] addr_i;
  reg [7:0] wdata_i, v;
  wire [7:0] rdata_o, md, ho;
  wire oe, sel_n, rd_n, wr_n, a0, ack_n, irq;
  integer failures = 0, check_count = 0, i, k;
  pic_host_ctrl uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dev_data_i(oe ? ho : md),
    .dev_data_o(ho), .dev_data_oe_o(oe), .select_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .cmd_select_addr_o(a0), .irq_ack_strobe_n_o(ack_n), .irq_i(irq));
  dev_model dev (.sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .ack_n(ack_n), .oe(oe),
    .hd(ho), .m16(m16), .req(req), .d(md), .irq(irq));
  initial
  begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  task chk(input string n, input [7:0] s, input [7:0] e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] x);
  begin
    @(posedge clk_i);
    addr_i <= a; wdata_i <= x; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  end
  endtask
  // Bounded poll of the status byte under a mask
  task wt(input [7:0] m, input [7:0] e);
  begin
    i = 0;
    rd(`REG_STATUS);
    while ((v & m) !== e && i < 60)
    begin
      i = i + 1;
      rd(`REG_STATUS);
    end
    chk("status", v & m, e);
  end
  endtask
  task t_reset;
  begin
    rd(`REG_STATUS); chk("status", v, 8'h00);
    rd(4'hF); chk("unmapped", v, 8'h00);
    $display("test reset done");
  end
  endtask
  task t_cmd;
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      wr(`REG_WDATA, 8'h3C + k[7:0]);
      wr(`REG_CTRL, 8'h01 | (k[7:0] << 2)); wt(8'h01, 8'h00);
      wr(`REG_CTRL, 8'h02 | (k[7:0] << 2)); wt(8'h01, 8'h00);
      rd(`REG_RDATA); chk("rdata", v, (8'h3C + k[7:0]) ^ 8'h5A);
    end
    // Read word 0 again while trying to overwrite the write byte mid-access
    wr(`REG_CTRL, 8'h02);
    wr(`REG_WDATA, 8'hA5);
    wt(8'h01, 8'h00);
    rd(`REG_RDATA); chk("rdata addr0", v, 8'h3C ^ 8'h5A);
    rd(`REG_WDATA); chk("wdata busy", v, 8'h3D);
    $display("test command done");
  end
  endtask
  task t_ack(input [7:0] c, input [3:0] a, input [7:0] e);
  begin
    req <= 1'b1;
    wr(`REG_CTRL, c); wt(8'h06, 8'h06);
    req <= 1'b0;
    rd(a); chk("vector", v, e);
    rd(`REG_STATUS); chk("opcode err", v & 8'h08, 8'h00);
    wt(8'h01, 8'h00);
    wr(`REG_CTRL, 8'h00);
    wr(`REG_STATUS, 8'h00);
    $display("test acknowledge done");
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    #2000000;
    failures = failures + 1;
    report_and_stop;
  end
  initial
  begin
    rstn_i = 0; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0; req = 0; m16 = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_cmd;
    t_ack(8'h08, `REG_VEC0, 8'hCD);
    t_ack(8'h08, `REG_VEC2, 8'h12);
    m16 <= 1'b1;
    t_ack(8'h18, `REG_VEC1, 8'h40);
    report_and_stop;
  end
endmodule // tb_top
